// ===== src/gdc_pkg.sv
package gdc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 40;

  // least time in ns to whole clock cycles, rounded up, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int MINON_T2_NS = 500;
  localparam int MINON_T3_NS = 750;
  localparam int MINON_T4_NS = 1000;
  localparam int MINON_T5_NS = 1250;
  localparam int MINON_T6_NS = 1500;
  localparam int MINON_T7_NS = 2000;
  localparam logic [7:0] MINON_C2 = 8'(ns_to_cyc(MINON_T2_NS));
  localparam logic [7:0] MINON_C3 = 8'(ns_to_cyc(MINON_T3_NS));
  localparam logic [7:0] MINON_C4 = 8'(ns_to_cyc(MINON_T4_NS));
  localparam logic [7:0] MINON_C5 = 8'(ns_to_cyc(MINON_T5_NS));
  localparam logic [7:0] MINON_C6 = 8'(ns_to_cyc(MINON_T6_NS));
  localparam logic [7:0] MINON_C7 = 8'(ns_to_cyc(MINON_T7_NS));
  localparam logic [7:0] MINON_C0 = 8'h00;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_INDEX = 8'hAE;
  localparam logic [7:0] STAT_INDEX = 8'hAF;
  localparam logic [11:0] CFG_ADDR = {2'h0, CFG_INDEX, 2'h0};
  localparam logic [11:0] STAT_ADDR = {2'h0, STAT_INDEX, 2'h0};
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] CFG_WR_MASK = 32'h81FE0000;

  // ---------------------------------------------------------------
  // config field positions and codes
  // ---------------------------------------------------------------
  localparam int PARITY_BIT = 31;
  localparam int SEQ_OFF_BIT = 24;
  localparam int CL_BIT = 23;
  localparam int VSEL_LSB = 21;
  localparam int OFF_BIT = 20;
  localparam int MINON_LSB = 17;
  localparam logic [2:0] MINON_ZERO = 3'h0;
  localparam logic [2:0] MINON_AUTO = 3'h1;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int ST_CYC_LSB = 0;
  localparam int ST_AUTO_BIT = 8;
  localparam int ST_RUN_BIT = 9;
  localparam int ST_VSEL_LSB = 10;
  localparam int ST_CL_BIT = 12;
  localparam int ST_SEQ_BIT = 13;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gdc_pkg

// ===== src/gdc_cfg_store.sv
`timescale 1ns/1ps
`default_nettype none
module gdc_cfg_store (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write request
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  // stored word
  output logic [31:0] cfg_word
);

  // byte strobes widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [31:0] keep;

  // merge enabled lanes, reserved bits keep their stored value
  always_comb begin
    keep = lane_mask(wr_strb) & gdc_pkg::CFG_WR_MASK;
    cfg_next = (cfg_reg & ~keep) | (wr_data & keep);
  end

  // storage, cleared by reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= gdc_pkg::CFG_RESET;
    end else if (wr_en) begin
      cfg_reg <= cfg_next;
    end
  end

  assign cfg_word = cfg_reg;

endmodule : gdc_cfg_store
`default_nettype wire

// ===== src/gdc_field_decode.sv
`timescale 1ns/1ps
`default_nettype none
module gdc_field_decode (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // stored word
  input wire logic [31:0] cfg_word,
  // applied controls
  output logic seq_off,
  output logic cur_lim_sel,
  output logic [1:0] volt_sel,
  output logic reg_off,
  output logic min_on_auto,
  output logic [7:0] min_on_cycles
);

  // on-time code to cycle count; auto reads as zero cycles
  function automatic logic [7:0] code_cyc(input logic [2:0] c);
    case (c)
      3'h2: code_cyc = gdc_pkg::MINON_C2;
      3'h3: code_cyc = gdc_pkg::MINON_C3;
      3'h4: code_cyc = gdc_pkg::MINON_C4;
      3'h5: code_cyc = gdc_pkg::MINON_C5;
      3'h6: code_cyc = gdc_pkg::MINON_C6;
      3'h7: code_cyc = gdc_pkg::MINON_C7;
      default: code_cyc = gdc_pkg::MINON_C0;
    endcase
  endfunction : code_cyc

  logic [2:0] code;
  assign code = cfg_word[gdc_pkg::MINON_LSB +: 3];

  // regulator controls follow the word one cycle late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_off <= 1'b0;
      cur_lim_sel <= 1'b0;
      volt_sel <= 2'h0;
      reg_off <= 1'b0;
    end else begin
      seq_off <= cfg_word[gdc_pkg::SEQ_OFF_BIT];
      cur_lim_sel <= cfg_word[gdc_pkg::CL_BIT];
      volt_sel <= cfg_word[gdc_pkg::VSEL_LSB +: 2];
      reg_off <= cfg_word[gdc_pkg::OFF_BIT];
    end
  end

  // low-side minimum on-time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      min_on_auto <= 1'b0;
      min_on_cycles <= 8'h00;
    end else begin
      min_on_auto <= (code == gdc_pkg::MINON_AUTO);
      min_on_cycles <= code_cyc(code);
    end
  end

endmodule : gdc_field_decode
`default_nettype wire

// ===== src/gdc_top.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module gdc_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // write address channel
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // write data channel
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // write response channel
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // read address channel
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // read data channel
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // regulator controls
  output logic REGULATOR_SEQUENCING_OFF,
  output logic REGULATOR_CURRENT_LIMIT_SEL,
  output logic [1:0] REGULATOR_VOLTAGE_SEL,
  output logic REGULATOR_OFF,
  // low-side minimum on-time
  output logic MIN_ON_AUTO,
  output logic [7:0] MIN_ON_CYCLES
);

  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic b_valid_reg;
  logic [1:0] b_resp_reg;
  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic wr_hit_cfg;
  logic wr_hit_stat;

  // each channel taken once, held until the response has gone
  assign S_AXI_AWREADY = !aw_held_reg && !b_valid_reg;
  assign S_AXI_WREADY = !w_held_reg && !b_valid_reg;
  assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_go = aw_held_reg && w_held_reg && !b_valid_reg;
  assign wr_hit_cfg = (aw_addr_reg[11:2] == gdc_pkg::CFG_ADDR[11:2]);
  assign wr_hit_stat = (aw_addr_reg[11:2] == gdc_pkg::STAT_ADDR[11:2]);

  // address hold
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (aw_fire) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end
  end

  // data hold
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (w_fire) begin
      w_held_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA;
      w_strb_reg <= S_AXI_WSTRB;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end
  end

  // write response; status index is read-only
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      b_valid_reg <= 1'b0;
      b_resp_reg <= gdc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      b_valid_reg <= 1'b1;
      b_resp_reg <= wr_hit_cfg ? gdc_pkg::RESP_OKAY
                               : gdc_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      b_valid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = b_valid_reg;
  assign S_AXI_BRESP = b_resp_reg;

  // ---------------------------------------------------------------
  // config word and applied fields
  // ---------------------------------------------------------------
  logic [31:0] cfg_word;
  logic wr_cfg;

  assign wr_cfg = wr_go && wr_hit_cfg;

  gdc_cfg_store u_store (
    .clk(CLOCK),
    .rst(RST),
    .wr_en(wr_cfg),
    .wr_data(w_data_reg),
    .wr_strb(w_strb_reg),
    .cfg_word(cfg_word)
  );

  gdc_field_decode u_decode (
    .clk(CLOCK),
    .rst(RST),
    .cfg_word(cfg_word),
    .seq_off(REGULATOR_SEQUENCING_OFF),
    .cur_lim_sel(REGULATOR_CURRENT_LIMIT_SEL),
    .volt_sel(REGULATOR_VOLTAGE_SEL),
    .reg_off(REGULATOR_OFF),
    .min_on_auto(MIN_ON_AUTO),
    .min_on_cycles(MIN_ON_CYCLES)
  );

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic r_valid_reg;
  logic [31:0] r_data_reg;
  logic [1:0] r_resp_reg;
  logic ar_fire;
  logic [31:0] stat_word;

  assign S_AXI_ARREADY = !r_valid_reg;
  assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;

  // status word shows the controls actually applied
  always_comb begin
    stat_word = 32'h00000000;
    stat_word[gdc_pkg::ST_CYC_LSB +: 8] = MIN_ON_CYCLES;
    stat_word[gdc_pkg::ST_AUTO_BIT] = MIN_ON_AUTO;
    stat_word[gdc_pkg::ST_RUN_BIT] = !REGULATOR_OFF;
    stat_word[gdc_pkg::ST_VSEL_LSB +: 2] = REGULATOR_VOLTAGE_SEL;
    stat_word[gdc_pkg::ST_CL_BIT] = REGULATOR_CURRENT_LIMIT_SEL;
    stat_word[gdc_pkg::ST_SEQ_BIT] = REGULATOR_SEQUENCING_OFF;
  end

  // read data, one cycle after the address is taken
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      r_valid_reg <= 1'b0;
      r_data_reg <= 32'h00000000;
      r_resp_reg <= gdc_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      r_valid_reg <= 1'b1;
      if (S_AXI_ARADDR[11:2] == gdc_pkg::CFG_ADDR[11:2]) begin
        r_data_reg <= cfg_word & gdc_pkg::CFG_WR_MASK;
        r_resp_reg <= gdc_pkg::RESP_OKAY;
      end else if (S_AXI_ARADDR[11:2] == gdc_pkg::STAT_ADDR[11:2]) begin
        r_data_reg <= stat_word;
        r_resp_reg <= gdc_pkg::RESP_OKAY;
      end else begin
        r_data_reg <= 32'h00000000;
        r_resp_reg <= gdc_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      r_valid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID = r_valid_reg;
  assign S_AXI_RDATA = r_data_reg;
  assign S_AXI_RRESP = r_resp_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // helper: set by the first write of any strobes to the config word
  logic seen_wr_reg;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      seen_wr_reg <= 1'b0;
    end else if (wr_cfg) begin
      seen_wr_reg <= 1'b1;
    end
  end

  sequence full_cfg_write;
    wr_cfg && (w_strb_reg == 4'hF);
  endsequence

  sequence cfg_read_issued;
    ar_fire && (S_AXI_ARADDR[11:2] == gdc_pkg::CFG_ADDR[11:2]);
  endsequence

  reset_zero_a:
    assert property (!seen_wr_reg |-> cfg_word == gdc_pkg::CFG_RESET)
    else $error("config word not zero before first write");

  store_read_a:
    assert property (cfg_read_issued |=>
                     S_AXI_RVALID && S_AXI_RDATA ==
                     ($past(cfg_word) & gdc_pkg::CFG_WR_MASK))
    else $error("config readback differs from stored word");

  seq_off_a:
    assert property (full_cfg_write |=> ##1
                     REGULATOR_SEQUENCING_OFF ==
                     $past(w_data_reg[gdc_pkg::SEQ_OFF_BIT], 2))
    else $error("sequencing control does not follow bit 24");

  cur_limit_a:
    assert property (full_cfg_write |=> ##1
                     REGULATOR_CURRENT_LIMIT_SEL ==
                     $past(w_data_reg[gdc_pkg::CL_BIT], 2))
    else $error("current limit does not follow bit 23");

  volt_sel_a:
    assert property (full_cfg_write |=> ##1
                     REGULATOR_VOLTAGE_SEL ==
                     $past(w_data_reg[22:21], 2))
    else $error("voltage select does not follow bits 22-21");

  reg_off_a:
    assert property ($rose(cfg_word[gdc_pkg::OFF_BIT]) |=>
                     REGULATOR_OFF ##1 stat_word[gdc_pkg::ST_RUN_BIT] == 1'b0)
    else $error("regulator not switched off after bit 20");

  min_on_max_a:
    assert property (cfg_word[19:17] == 3'h7 |=>
                     MIN_ON_CYCLES == 8'h50 && !MIN_ON_AUTO)
    else $error("2 us on-time not 80 cycles");

  min_on_auto_a:
    assert property (cfg_word[19:17] == 3'h1 |=>
                     MIN_ON_AUTO && MIN_ON_CYCLES == 8'h00)
    else $error("automatic on-time not flagged");

  min_on_half_a:
    assert property (cfg_word[19:17] == 3'h2 |=> MIN_ON_CYCLES == 8'h14)
    else $error("0.5 us on-time not 20 cycles");

  reserved_zero_a:
    assert property ((cfg_word & ~gdc_pkg::CFG_WR_MASK) == 32'h00000000)
    else $error("reserved config bit became set");

  bresp_hold_a:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
                     S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before ready");

  rdata_hold_a:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
                     S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before ready");

  aw_refused_a:
    assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write channel open while response pending");

  ar_refused_a:
    assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address open while data pending");

  stat_write_a:
    assert property (wr_go && wr_hit_stat |=>
                     S_AXI_BRESP == gdc_pkg::RESP_SLVERR &&
                     $stable(cfg_word))
    else $error("write to status word not refused");

  unmap_read_a:
    assert property (ar_fire && S_AXI_ARADDR[11:2] != gdc_pkg::CFG_ADDR[11:2]
                     && S_AXI_ARADDR[11:2] != gdc_pkg::STAT_ADDR[11:2] |=>
                     S_AXI_RRESP == gdc_pkg::RESP_SLVERR &&
                     S_AXI_RDATA == 32'h00000000)
    else $error("unmapped read not refused");

  min_on_zero_a:
    assert property (cfg_word[19:17] == 3'h0 |=>
                     MIN_ON_CYCLES == 8'h00 && !MIN_ON_AUTO)
    else $error("zero on-time not zero cycles");

  min_on_three_a:
    assert property (cfg_word[19:17] == 3'h3 |=> MIN_ON_CYCLES == 8'h1E)
    else $error("0.75 us on-time not 30 cycles");

  min_on_four_a:
    assert property (cfg_word[19:17] == 3'h4 |=> MIN_ON_CYCLES == 8'h28)
    else $error("1 us on-time not 40 cycles");

  min_on_five_a:
    assert property (cfg_word[19:17] == 3'h5 |=> MIN_ON_CYCLES == 8'h32)
    else $error("1.25 us on-time not 50 cycles");

  min_on_six_a:
    assert property (cfg_word[19:17] == 3'h6 |=> MIN_ON_CYCLES == 8'h3C)
    else $error("1.5 us on-time not 60 cycles");

endmodule : gdc_top
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ---------------------------------------------------------------
  // clock, reset and bus signals
  // ---------------------------------------------------------------
  localparam logic [31:0] KEEP = 32'h81FE0000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic seq_off, cur_lim, reg_off, min_auto;
  logic [1:0] vsel;
  logic [7:0] min_cyc;
  int miscompares = 0;
  int compares = 0;
  int ns_t [8] = '{0, 0, 500, 750, 1000, 1250, 1500, 2000};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  gdc_top uut (
    .CLOCK(clk), .RST(rst),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .REGULATOR_SEQUENCING_OFF(seq_off),
    .REGULATOR_CURRENT_LIMIT_SEL(cur_lim),
    .REGULATOR_VOLTAGE_SEL(vsel), .REGULATOR_OFF(reg_off),
    .MIN_ON_AUTO(min_auto), .MIN_ON_CYCLES(min_cyc)
  );

  // ---------------------------------------------------------------
  // verdict and comparisons
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_resp(input string nm, input logic [1:0] e,
                          input logic [1:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_resp

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw_p, w_p, b_p;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    while (aw_p || w_p || b_p) begin
      @(posedge clk);
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
      if (b_p && bvalid === 1'b1) begin
        b_p = 1'b0;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_p, r_p;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    ar_p = 1'b1;
    r_p = 1'b1;
    while (ar_p || r_p) begin
      @(posedge clk);
      if (ar_p && arready === 1'b1) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
      end
      if (r_p && rvalid === 1'b1) begin
        r_p = 1'b0;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask : axi_rd

  // applied controls and status word against the stored word, after lag
  task automatic chk_ctl(input logic [31:0] w);
    int code;
    logic [31:0] se, sd;
    logic [1:0] sr;
    code = int'(w[19:17]);
    se = {18'h00000, w[24], w[23], w[22:21], ~w[20], w[19:17] == 3'h1,
          8'(ns_t[code] / 25)};
    repeat (2) @(posedge clk);
    axi_rd(gdc_pkg::STAT_ADDR, sd, sr);
    chk_resp("stat_rresp", gdc_pkg::RESP_OKAY, sr);
    chk_word("status", se, sd);
    chk_word("seq_off", 32'(w[24]), 32'(seq_off));
    chk_word("cur_lim", 32'(w[23]), 32'(cur_lim));
    chk_word("volt_sel", 32'(w[22:21]), 32'(vsel));
    chk_word("reg_off", 32'(w[20]), 32'(reg_off));
    chk_word("min_auto", 32'(code == 1), 32'(min_auto));
    chk_word("min_cyc", 32'(ns_t[code] / 25), 32'(min_cyc));
  endtask : chk_ctl

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin : main
    logic [31:0] d, w;
    logic [1:0] r;
    logic [2:0] b;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    axi_rd(gdc_pkg::CFG_ADDR, d, r);
    chk_word("reset_word", 32'h00000000, d);
    chk_resp("reset_rresp", gdc_pkg::RESP_OKAY, r);
    chk_ctl(32'h00000000);
    // every code of each field except parity, which stays zero; reserved bits written as ones
    for (int i = 0; i < 8; i++) begin
      b = 3'(i);
      w = 32'h7E01FFFF | {7'h0, b[0], b[1], b[1:0], b[2], b, 17'h0};
      axi_wr(gdc_pkg::CFG_ADDR, w, 4'hF, r);
      chk_resp("wr_bresp", gdc_pkg::RESP_OKAY, r);
      axi_rd(gdc_pkg::CFG_ADDR, d, r);
      chk_word("cfg_word", w & KEEP, d);
      chk_ctl(w);
    end
    axi_wr(gdc_pkg::CFG_ADDR, 32'hFFFFFFFF, 4'hF, r);
    axi_rd(gdc_pkg::CFG_ADDR, d, r);
    chk_word("all_ones", KEEP, d);
    // only byte lane 2 cleared
    axi_wr(gdc_pkg::CFG_ADDR, 32'h00000000, 4'h4, r);
    axi_rd(gdc_pkg::CFG_ADDR, d, r);
    chk_word("lane_two", 32'h81000000, d);
    chk_ctl(32'h81000000);
    // unmapped place refused and harmless
    axi_wr(12'h100, 32'h00000000, 4'hF, r);
    chk_resp("unmap_bresp", gdc_pkg::RESP_SLVERR, r);
    axi_rd(12'h104, d, r);
    chk_resp("unmap_rresp", gdc_pkg::RESP_SLVERR, r);
    chk_word("unmap_data", 32'h00000000, d);
    axi_wr(gdc_pkg::STAT_ADDR, 32'hFFFFFFFF, 4'hF, r);
    chk_resp("stat_bresp", gdc_pkg::RESP_SLVERR, r);
    axi_rd(gdc_pkg::CFG_ADDR, d, r);
    chk_word("kept_word", 32'h81000000, d);
    // second reset in mid-run clears everything again
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    axi_rd(gdc_pkg::CFG_ADDR, d, r);
    chk_word("rerst_word", 32'h00000000, d);
    chk_ctl(32'h00000000);
    stop_test();
  end : main

  // hang guard, well beyond the roughly 150 cycles needed
  initial begin : watchdog
    #100000;
    miscompares++;
    stop_test();
  end : watchdog
endmodule : tb_top
`default_nettype wire
